// ---- rpwm_pkg.sv ----
// Package: constants, register map and types for the random PWM six-phase gate drive
// Function
// - Random bit from XOR-fed shift chain
// - Random chain advances at 12.5 kHz
// - Carriers load full, count down at 1.6875 MHz
// - Carrier terminal value 134, 80 us period
// - Carrier A starts 40 us after B
// - Compare carriers with reference on 0..134 scale
// - Train is A with bit, B without bit
// - Base counter pulses every 10 ms
// - Toggle flop makes 50 Hz square wave
// - Three cascaded counters give 3.33 ms pulses
// - Sixth-period pulses inverted before delay line
// - Delay line gives 3.33 and 6.66 ms copies
// - Square, copies, inversions form six windows
// - Each window ANDed with train to gates
// - Reference limited to half..full scale
package rpwm_pkg;
  // Clock and timing figures
  localparam int CLK_HZ         = 100_000_000;
  localparam int CAR_TICK_HZ    = 1_687_500;
  localparam int CAR_TICK_CYC   = CLK_HZ / CAR_TICK_HZ;
  localparam int LFSR_HZ        = 12_500;
  localparam int LFSR_CYC       = CLK_HZ / LFSR_HZ;
  localparam int START_DLY_NS   = 40_000;
  localparam int CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int START_DLY_CYC  = (START_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BASE_US        = 10_000;
  localparam int BASE_CYC       = BASE_US * (CLK_HZ / 1_000_000);
  localparam int SIXTH_US       = 3_330;
  localparam int SIXTH_CYC      = SIXTH_US * (CLK_HZ / 1_000_000);
  localparam int SIXTH_DIV1     = 100;
  localparam int SIXTH_DIV2     = 10;
  localparam int SIXTH_DIV3     = SIXTH_CYC / (SIXTH_DIV1 * SIXTH_DIV2);
  // Carrier scale
  localparam logic [7:0] CAR_TOP   = 8'h86;  // 134
  localparam logic [7:0] REF_HALF  = 8'h43;  // 67
  localparam logic [6:0] LFSR_SEED = 7'h01;
  // Register offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] REF_OFS    = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] CARRIER_OFS = 12'h00c;
  // Field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int ST_RBIT_BIT   = 0;
  localparam int ST_SQ_BIT     = 1;
  localparam int ST_WIN_LSB    = 2;
  localparam int ST_CMPA_BIT   = 8;
  localparam int ST_CMPB_BIT   = 9;
  localparam int ST_TRAIN_BIT  = 10;
  localparam int CAR_B_LSB     = 8;
  // Reset values
  localparam logic       CTRL_RST = 1'b0;
  localparam logic [7:0] REF_RST  = REF_HALF;
  // Start-up sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } rpwm_state_t;
endpackage

// ---- rpwm_dly_if.sv ----
// Interface: carrier between the timing core and the two-stage delay line
`timescale 1ns/100ps
interface rpwm_dly_if;
  logic ce;
  logic clr;
  logic step_n;
  logic square;
  logic delay_1;
  logic delay_2;
  modport src  (output ce, clr, step_n, square, input delay_1, delay_2);
  modport line (input ce, clr, step_n, square, output delay_1, delay_2);
endinterface

// ---- rpwm_delay_line.sv ----
// Module: two-stage delay line stepping on rising edges of its step input
`timescale 1ns/100ps
module rpwm_delay_line (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Carrier
  rpwm_dly_if.line dl
);
  logic       step_prev_q;
  logic [1:0] stage_q;
  logic       step_rise;

  // Step on rising edges only, matching the inverted sixth-period train
  assign step_rise = dl.step_n & ~step_prev_q;

  // Edge memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_prev_q <= 1'b1;
    end else if (dl.ce) begin
      step_prev_q <= dl.clr ? 1'b1 : dl.step_n;
    end
  end

  // Shift the square wave one sixth-period per stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q <= 2'h0;
    end else if (dl.ce) begin
      if (dl.clr) begin
        stage_q <= 2'h0;
      end else if (step_rise) begin
        stage_q <= {stage_q[0], dl.square};
      end
    end
  end

  assign dl.delay_1 = stage_q[0];
  assign dl.delay_2 = stage_q[1];

  property p_dly_shift;
    @(posedge pclk) disable iff (!presetn)
      dl.ce && !dl.clr && step_rise |=> stage_q == {$past(stage_q[0]), $past(dl.square)};
  endproperty
  a_dly_shift: assert property (p_dly_shift) else $error("delay line did not shift");
endmodule

// ---- rpwm_gate_drive.sv ----
// Module: random PWM six-phase gate drive with APB register slave
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
module rpwm_gate_drive #(
  parameter int LFSR_DIV   = rpwm_pkg::LFSR_CYC,
  parameter int BASE_DIV   = rpwm_pkg::BASE_CYC,
  parameter int SIXTH_DIV3 = rpwm_pkg::SIXTH_DIV3
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Gate drive
  output logic      [5:0]  gate_drive
);
  import rpwm_pkg::*;

  localparam int LW = $clog2(LFSR_DIV);
  localparam int BW = $clog2(BASE_DIV);
  localparam int SW = $clog2(SIXTH_DIV3);
  localparam int DW = $clog2(START_DLY_CYC);
  localparam int PW = $clog2(CAR_TICK_CYC);

  // Counts the logic cannot serve
  if (LFSR_DIV < 2 || BASE_DIV < 2 || SIXTH_DIV3 < 2) begin : g_bad_div
    $error("rpwm_gate_drive: dividers must be at least 2");
  end

  logic        run_q;
  logic [7:0]  ref_q;
  rpwm_state_t st_q;
  logic [DW-1:0] dly_cnt_q;
  logic [LW-1:0] lfsr_div_q;
  logic [6:0]  lfsr_q;
  logic        lfsr_tick;
  logic        random_bit;
  logic [PW-1:0] pre_q [2];
  logic [7:0]  car_q [2];
  logic [1:0]  car_en;
  logic [1:0]  car_tick;
  logic [1:0]  cmp;
  logic        random_pulse_train;
  logic [BW-1:0] base_cnt_q;
  logic        base_tick;
  logic        sq_q;
  logic [1:0]  sq_pipe_q;
  logic [6:0]  six1_q;
  logic [3:0]  six2_q;
  logic [SW-1:0] six3_q;
  logic        six1_wrap;
  logic        six2_wrap;
  logic        six_pulse_q;
  logic [5:0]  conduction_windows;
  logic        acc_en;
  logic        wr_en;
  logic        mapped;
  logic [7:0]  ref_wr;

  rpwm_dly_if dly ();

  // APB: always ready while clock-enabled, so state never moves mid-freeze
  assign pready  = ce;
  assign acc_en  = psel & penable & ce;
  assign wr_en   = acc_en & pwrite;
  assign mapped  = (paddr == CTRL_OFS) | (paddr == REF_OFS) |
                   (paddr == STATUS_OFS) | (paddr == CARRIER_OFS);
  assign pslverr = psel & penable & ~mapped;

  // Clamp writes into half..full scale; lower values worsen the spectrum
  always_comb begin
    ref_wr = pwdata[7:0];
    if (pwdata[31:8] != 24'h0 || pwdata[7:0] > CAR_TOP) begin
      ref_wr = CAR_TOP;
    end else if (pwdata[7:0] < REF_HALF) begin
      ref_wr = REF_HALF;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= CTRL_RST;
    end else if (wr_en && paddr == CTRL_OFS) begin
      run_q <= pwdata[CTRL_RUN_BIT];
    end
  end

  // Reference register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= REF_RST;
    end else if (wr_en && paddr == REF_OFS) begin
      ref_q <= ref_wr;
    end
  end

  // Read data registered at the setup-phase edge (psel high, penable low)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable) begin
      case (paddr)
        CTRL_OFS:    prdata <= {31'h0, run_q};
        REF_OFS:     prdata <= {24'h0, ref_q};
        STATUS_OFS:  prdata <= {21'h0, random_pulse_train, cmp, conduction_windows,
                                sq_q, random_bit};
        CARRIER_OFS: prdata <= {16'h0, car_q[1], car_q[0]};
        default:     prdata <= 32'h0;
      endcase
    end
  end

  // Start-up: carrier B runs first, A joins half a carrier period later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= ST_IDLE;
      dly_cnt_q <= '0;
    end else if (ce) begin
      if (!run_q) begin
        st_q      <= ST_IDLE;
        dly_cnt_q <= '0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_WAIT;
          end
          ST_WAIT: begin
            if (dly_cnt_q == DW'(START_DLY_CYC - 1)) begin
              st_q <= ST_RUN;
            end else begin
              dly_cnt_q <= dly_cnt_q + 1'b1;
            end
          end
          ST_RUN: begin
            st_q <= ST_RUN;
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign car_en[1] = (st_q != ST_IDLE);
  assign car_en[0] = (st_q == ST_RUN);

  // Random chain divider
  assign lfsr_tick = run_q & (lfsr_div_q == LW'(LFSR_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_div_q <= '0;
    end else if (ce) begin
      lfsr_div_q <= (!run_q || lfsr_tick) ? '0 : lfsr_div_q + 1'b1;
    end
  end

  // Seven-stage chain, taps 7 and 6, maximal length; seed keeps it off zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= LFSR_SEED;
    end else if (ce && lfsr_tick) begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
    end
  end
  assign random_bit = lfsr_q[0];

  // Two carriers, each with its own prescaler
  for (genvar i = 0; i < 2; i++) begin : g_car
    assign car_tick[i] = car_en[i] & (pre_q[i] == PW'(CAR_TICK_CYC - 1));

    // Prescaler
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_q[i] <= '0;
      end else if (ce) begin
        pre_q[i] <= (!car_en[i] || car_tick[i]) ? '0 : pre_q[i] + 1'b1;
      end
    end

    // Down-counting sawtooth, reloaded with the terminal value
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        car_q[i] <= CAR_TOP;
      end else if (ce) begin
        if (!car_en[i]) begin
          car_q[i] <= CAR_TOP;
        end else if (car_tick[i]) begin
          car_q[i] <= (car_q[i] == 8'h0) ? CAR_TOP : car_q[i] - 8'h1;
        end
      end
    end

    // Larger reference gives a wider pulse
    assign cmp[i] = car_en[i] & (car_q[i] < ref_q);
  end

  // Random choice between the two compare pulses
  assign random_pulse_train = (cmp[0] & random_bit) | (cmp[1] & ~random_bit);

  // Base period counter and square wave
  assign base_tick = run_q & (base_cnt_q == BW'(BASE_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_q <= '0;
    end else if (ce) begin
      base_cnt_q <= (!run_q || base_tick) ? '0 : base_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_q <= 1'b0;
    end else if (ce) begin
      if (!run_q) begin
        sq_q <= 1'b0;
      end else if (base_tick) begin
        sq_q <= ~sq_q;
      end
    end
  end

  // Square delayed to match the step pipeline, so a step that meets a toggle
  // still takes the level from before it and each stage delays a full sixth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_pipe_q <= 2'h0;
    end else if (ce) begin
      sq_pipe_q <= run_q ? {sq_pipe_q[0], sq_q} : 2'h0;
    end
  end

  // Three cascaded counters for the sixth-period pulse
  assign six1_wrap = run_q & (six1_q == 7'(SIXTH_DIV1 - 1));
  assign six2_wrap = six1_wrap & (six2_q == 4'(SIXTH_DIV2 - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six1_q      <= '0;
      six2_q      <= '0;
      six3_q      <= '0;
      six_pulse_q <= 1'b0;
    end else if (ce) begin
      six_pulse_q <= six2_wrap & (six3_q == SW'(SIXTH_DIV3 - 1));
      if (!run_q) begin
        six1_q <= '0;
        six2_q <= '0;
        six3_q <= '0;
      end else begin
        six1_q <= six1_wrap ? '0 : six1_q + 1'b1;
        if (six1_wrap) begin
          six2_q <= six2_wrap ? '0 : six2_q + 1'b1;
        end
        if (six2_wrap) begin
          six3_q <= (six3_q == SW'(SIXTH_DIV3 - 1)) ? '0 : six3_q + 1'b1;
        end
      end
    end
  end

  // Delay line hookup; its step edge follows the pulse's falling edge
  assign dly.ce     = ce;
  assign dly.clr    = ~run_q;
  assign dly.step_n = ~six_pulse_q;
  assign dly.square = sq_pipe_q[1];

  rpwm_delay_line u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .dl      (dly.line)
  );

  // Six windows in 60 degree phase order
  assign conduction_windows = {~dly.delay_2, ~dly.delay_1, ~sq_pipe_q[1],
                               dly.delay_2, dly.delay_1, sq_pipe_q[1]};

  // Registered gates; dead time is left to the external driver stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_drive <= 6'h0;
    end else if (ce) begin
      gate_drive <= conduction_windows & {6{random_pulse_train & run_q}};
    end
  end

  // Checks
  sequence s_wait_end;
    st_q == ST_WAIT && dly_cnt_q == DW'(START_DLY_CYC - 1) && ce && run_q;
  endsequence

  property p_lfsr_nonzero;
    @(posedge pclk) disable iff (!presetn) lfsr_q != 7'h0;
  endproperty
  a_lfsr_nonzero: assert property (p_lfsr_nonzero) else $error("random chain at zero");

  property p_lfsr_step;
    @(posedge pclk) disable iff (!presetn)
      ce && lfsr_tick |=> lfsr_q == {$past(lfsr_q[5:0]), $past(lfsr_q[6]) ^ $past(lfsr_q[5])};
  endproperty
  a_lfsr_step: assert property (p_lfsr_step) else $error("random chain step wrong");

  property p_lfsr_hold;
    @(posedge pclk) disable iff (!presetn)
      !(ce && lfsr_tick) |=> $stable(lfsr_q);
  endproperty
  a_lfsr_hold: assert property (p_lfsr_hold) else $error("random chain moved off tick");

  property p_car_wrap;
    @(posedge pclk) disable iff (!presetn)
      ce && car_tick[1] && car_q[1] == 8'h0 |=> car_q[1] == CAR_TOP;
  endproperty
  a_car_wrap: assert property (p_car_wrap) else $error("carrier did not reload");

  property p_car_down;
    @(posedge pclk) disable iff (!presetn)
      ce && car_tick[0] && car_q[0] != 8'h0 |=> car_q[0] == $past(car_q[0]) - 8'h1;
  endproperty
  a_car_down: assert property (p_car_down) else $error("carrier did not count down");

  property p_start_delay;
    @(posedge pclk) disable iff (!presetn)
      s_wait_end |=> st_q == ST_RUN ##0 car_q[0] == CAR_TOP && car_en[0];
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("carrier A start late");

  property p_ref_range;
    @(posedge pclk) disable iff (!presetn) ref_q >= REF_HALF && ref_q <= CAR_TOP;
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference out of range");

  property p_square;
    @(posedge pclk) disable iff (!presetn)
      ce && base_tick |=> sq_q != $past(sq_q);
  endproperty
  a_square: assert property (p_square) else $error("square wave did not toggle");

  property p_six_pulse_one;
    @(posedge pclk) disable iff (!presetn) ce && six_pulse_q |=> !six_pulse_q;
  endproperty
  a_six_pulse_one: assert property (p_six_pulse_one) else $error("sixth pulse too wide");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
      ce && run_q |=> gate_drive == ($past(conduction_windows) & {6{$past(cmp[0] & random_bit)
                      | $past(cmp[1] & ~random_bit)}});
  endproperty
  a_gate: assert property (p_gate) else $error("gate drive mismatch");
endmodule

// ---- rpwm_gate_driver_model.sv ----
// Partner model: gate driver that adds turn-on dead time per switch
`timescale 1ns/100ps
module rpwm_gate_driver_model #(
  parameter int DEAD = 4
) (
  // Clock
  input  wire logic       pclk,
  // Gate commands in, switch states out
  input  wire logic [5:0] gate,
  output logic      [5:0] sw_on
);
  logic [3:0] age_q [6];
  // Count cycles a command is high; turn-on waits DEAD cycles, turn-off is at once
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 6; i++) begin
      age_q[i] <= !gate[i] ? 4'h0 : (age_q[i] < DEAD) ? age_q[i] + 4'h1 : age_q[i];
    end
  end
  // Switch conducts only after the dead time has run out
  always_comb begin
    for (int i = 0; i < 6; i++) sw_on[i] = gate[i] && (age_q[i] >= DEAD);
  end
endmodule

// ---- tb.sv ----
// Testbench: APB-driven scenarios for the random PWM gate drive
`timescale 1ns/100ps
module tb;
  import rpwm_pkg::*;
  logic        pclk = 0, presetn = 0, ce = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, s, c;
  logic        pready, pslverr, e, saw = 1'b0;
  logic [5:0]  gate_drive, sw_on;
  int          errors = 0, total_checks = 0, cyc = 0;
  // Small dividers: sixth period 2000 cycles, six of them per square period
  rpwm_gate_drive #(.LFSR_DIV(8), .BASE_DIV(6000), .SIXTH_DIV3(2)) rpwm_gate_drive_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gate_drive(gate_drive));
  rpwm_gate_driver_model rpwm_gate_driver_model_i (.pclk(pclk), .gate(gate_drive), .sw_on(sw_on));
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cycle count and leg monitor: both switches of a leg never on together
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (gate_drive !== 6'h00) saw <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (presetn && (gate_drive[i] & gate_drive[i+3]) !== 1'b0) chk(1, 0);
      if (presetn && (sw_on[i] & sw_on[i+3]) !== 1'b0) chk(1, 0);
    end
  end
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
    v = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 100) begin chk(0, 1); tally_and_finish(); end
  endtask
  // Relations inside one status snapshot
  task automatic st_chk();
    chk(s[10], (s[8] & s[0]) | (s[9] & ~s[0]));
    chk(s[7:5] ^ s[4:2], 32'h7);
  endtask
  task automatic t_reset_vals();
    apb(0, CTRL_OFS, 0); chk(v, 0);
    apb(0, REF_OFS, 0); chk(v, 32'h43);
    chk(gate_drive, 0);
  endtask
  task automatic t_ref_clamp();
    logic [31:0] wv [7] = '{32'h10, 32'h42, 32'h43, 32'h6b, 32'h86, 32'h87, 32'h105};
    for (int i = 0; i < 7; i++) begin
      apb(1, REF_OFS, wv[i]); apb(0, REF_OFS, 0);
      chk(v, wv[i] < 32'h43 ? 32'h43 : wv[i] > 32'h86 ? 32'h86 : wv[i]);
    end
  endtask
  task automatic t_unmapped();
    apb(1, 12'h010, 32'h1); chk(e, 1);
    apb(0, 12'h010, 0); chk(e, 1); chk(v, 0);
    apb(0, CTRL_OFS, 0); chk(e, 0); chk(v, 0);
  endtask
  task automatic t_run_carriers();
    int b1, d;
    apb(1, CTRL_OFS, 1);
    repeat (2000) @(posedge pclk);
    apb(0, CARRIER_OFS, 0);
    chk(v[7:0], CAR_TOP);
    chk(v[15:8] < CAR_TOP, 1);
    repeat (3000) @(posedge pclk);
    apb(0, CARRIER_OFS, 0); b1 = v[15:8];
    // Reads 590 cycles apart: exactly ten carrier steps
    repeat (587) @(posedge pclk);
    apb(0, CARRIER_OFS, 0);
    chk(v[15:8], 32'((b1 + 125) % 135));
    d = (int'(v[15:8]) - int'(v[7:0]) + 135) % 135;
    chk(d == 67 || d == 68, 1);
  endtask
  task automatic t_compare();
    apb(1, REF_OFS, 32'h6b);
    for (int i = 0; i < 20; i++) begin
      apb(0, CARRIER_OFS, 0); c = v;
      apb(0, STATUS_OFS, 0); s = v;
      apb(0, CARRIER_OFS, 0);
      // Skip snapshots that straddle a carrier step
      if (v === c) begin
        chk(s[8], c[7:0] < 8'h6b);
        chk(s[9], c[15:8] < 8'h6b);
      end
      st_chk();
      repeat (40) @(posedge pclk);
    end
    apb(1, REF_OFS, 32'h43);
  endtask
  task automatic t_random_bit();
    int last, chg, gap;
    logic p;
    chg = 0; gap = 1000; last = cyc;
    apb(0, STATUS_OFS, 0); p = v[0];
    for (int i = 0; i < 60; i++) begin
      apb(0, STATUS_OFS, 0); s = v; st_chk();
      if (s[0] !== p) begin
        if (chg > 0 && cyc - last < gap) gap = cyc - last;
        chg++; last = cyc; p = s[0];
      end
    end
    chk(chg > 4, 1);
    chk(gap >= 6, 1);
  endtask
  task automatic t_square();
    int t0, n;
    logic p;
    n = 0; t0 = 0;
    apb(0, STATUS_OFS, 0); p = v[1];
    for (int i = 0; i < 6000 && n < 2; i++) begin
      apb(0, STATUS_OFS, 0); s = v; st_chk();
      if (s[1] !== p) begin
        if (n == 1) chk(cyc - t0 >= 5997 && cyc - t0 <= 6003, 1);
        n++; t0 = cyc; p = s[1];
      end
    end
    chk(n, 2);
    chk(saw, 1);
  endtask
  // Windows 0, 1 and 2 change one sixth period (2000 cycles) apart
  task automatic t_delay_line();
    int t [3];
    logic p;
    apb(0, STATUS_OFS, 0); p = v[2];
    for (int k = 0; k < 3; k++) begin
      t[k] = 0;
      for (int i = 0; i < 3000 && t[k] == 0; i++) begin
        apb(0, STATUS_OFS, 0); s = v; st_chk();
        if (s[2 + k] !== p) t[k] = cyc;
      end
    end
    chk(t[1] - t[0] >= 1997 && t[1] - t[0] <= 2003, 1);
    chk(t[2] - t[1] >= 1997 && t[2] - t[1] <= 2003, 1);
  endtask
  task automatic t_ce_freeze();
    int b1;
    apb(0, CARRIER_OFS, 0); b1 = v[15:8];
    ce <= 0;
    repeat (3) @(posedge pclk);
    chk(pready, 0);
    repeat (300) @(posedge pclk);
    ce <= 1;
    apb(0, CARRIER_OFS, 0);
    chk((b1 - int'(v[15:8]) + 135) % 135 <= 1, 1);
  endtask
  task automatic t_stop();
    apb(1, CTRL_OFS, 0);
    repeat (3) @(posedge pclk);
    chk(gate_drive, 0);
    apb(0, CARRIER_OFS, 0); chk(v, 32'h8686);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset_vals();
    t_ref_clamp();
    t_unmapped();
    t_run_carriers();
    t_compare();
    t_random_bit();
    t_square();
    t_delay_line();
    t_ce_freeze();
    t_stop();
    tally_and_finish();
  end
endmodule
